//--- adc_capture_model.sv
`timescale 1ns/1ps
module adc_capture_model #(
  parameter WIDTH = 16
) (
  input wire latchClock,
  input wire descramble,
  input wire [WIDTH-1:0] dataIn,
  input wire flagIn,
  output logic [WIDTH-1:0] word,
  output logic flag
);
  always @(posedge latchClock) begin
    word <= descramble ? dataIn ^ {{(WIDTH-1){dataIn[0]}}, 1'b0} : dataIn;
    flag <= flagIn;
  end
endmodule

//--- adc_out_defines.vh
`ifndef ADC_OUT_DEFINES_VH
`define ADC_OUT_DEFINES_VH
// ************************************************************
// Register map (AXI4-Lite byte addresses)
// ************************************************************
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_MASK 4'h8
`define REG_SAMPLE 4'hC
// ************************************************************
// Control fields
// ************************************************************
`define CTRL_DITHER_BIT 0
`define CTRL_RESET_VAL 32'h00000000
// ************************************************************
// Interrupt status fields
// ************************************************************
`define ST_SAMPLE_BIT 0
`define ST_RANGE_BIT 1
`define ST_WIDTH 2
// ************************************************************
// Generator and response codes
// ************************************************************
`define LFSR_SEED 16'hACE1
`define LFSR_TAPS 16'hB400
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

//--- adc_output_scrambler_out_clock_true.v
`timescale 1ns/1ps
`include "adc_out_defines.vh"
// Functional notes
// - Drive delayed sample clock on true and complement outputs.
// - Data outputs change as true clock falls and complement rises.
// - When scrambling, XOR every non-LSB data bit with the LSB.
// - Scrambling leaves LSB, range flag and output clocks untouched.
// - Scramble only while scramble enable is high, else plain word.
// - Dither mode switchable; off means no dither value involved.
// - Dither value comes each sample from long-sequence pseudo-random generator.
// - Subtract the same injected dither value from that sample's result.
// - Each result is a sixteen-bit parallel word.
// - Output word offset binary or two's complement per format input.
// - Range flag high when input exceeds range either way, else low.
module adc_output_scrambler_out_clock_true #(
  parameter WIDTH = 16
) (
  input wire clk,
  input wire reset,
  input wire sampleClock,
  input wire [WIDTH-1:0] rawResult,
  input wire overRange,
  input wire underRange,
  input wire scramble_enable,
  input wire formatTwos,
  output reg [WIDTH-1:0] dataOut,
  output reg range_exceeded_flag,
  output reg out_clock_true,
  output reg out_clock_comp,
  output reg [WIDTH-1:0] ditherOut,
  output reg irq,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  // ************************************************************
  // Input synchronisers
  // ************************************************************
  reg [2:0] clkSync_reg;
  reg [1:0] scrSync_reg;
  reg [1:0] fmtSync_reg;
  reg [1:0] ovSync_reg;
  reg [1:0] unSync_reg;
  reg [WIDTH-1:0] dataMeta_reg;
  reg [WIDTH-1:0] dataSync_reg;
  wire sampleRise;
  wire sampleFall;

  always @(posedge clk) begin
    if (reset) begin
      clkSync_reg <= 3'h0;
      scrSync_reg <= 2'h0;
      fmtSync_reg <= 2'h0;
      ovSync_reg <= 2'h0;
      unSync_reg <= 2'h0;
      dataMeta_reg <= {WIDTH{1'b0}};
      dataSync_reg <= {WIDTH{1'b0}};
    end else begin
      clkSync_reg <= {clkSync_reg[1:0], sampleClock};
      scrSync_reg <= {scrSync_reg[0], scramble_enable};
      fmtSync_reg <= {fmtSync_reg[0], formatTwos};
      ovSync_reg <= {ovSync_reg[0], overRange};
      unSync_reg <= {unSync_reg[0], underRange};
      dataMeta_reg <= rawResult;
      dataSync_reg <= dataMeta_reg;
    end
  end

  assign sampleRise = clkSync_reg[1] & ~clkSync_reg[2];
  assign sampleFall = ~clkSync_reg[1] & clkSync_reg[2];

  // ************************************************************
  // Output word pipeline
  // ************************************************************
  reg [31:0] ctrl_reg;
  wire [WIDTH-1:0] prngValue;
  wire [WIDTH-1:0] corrected;
  wire [WIDTH-1:0] formatted;
  wire [WIDTH-1:0] scrambled;
  wire overflowNow;

  function [WIDTH-1:0] scramble;
    input [WIDTH-1:0] word;
    begin
      scramble = word ^ {{(WIDTH-1){word[0]}}, 1'b0};
    end
  endfunction

  dither_prng #(
    .WIDTH(WIDTH)
  ) uPrng (
    .clk(clk),
    .reset(reset),
    .step(sampleRise),
    .value(prngValue)
  );

  // Raw result carries the value injected at this sample, which the
  // generator still holds until the next sample rise
  assign corrected = ctrl_reg[`CTRL_DITHER_BIT] ? (dataSync_reg - prngValue) : dataSync_reg;
  assign formatted = fmtSync_reg[1] ? {~corrected[WIDTH-1], corrected[WIDTH-2:0]} : corrected;
  assign scrambled = scrSync_reg[1] ? scramble(formatted) : formatted;
  assign overflowNow = ovSync_reg[1] | unSync_reg[1];

  always @(posedge clk) begin
    if (reset) begin
      dataOut <= {WIDTH{1'b0}};
      range_exceeded_flag <= 1'b0;
      out_clock_true <= 1'b0;
      out_clock_comp <= 1'b1;
      ditherOut <= {WIDTH{1'b0}};
    end else begin
      if (sampleRise) begin
        out_clock_true <= 1'b1;
        out_clock_comp <= 1'b0;
      end else if (sampleFall) begin
        out_clock_true <= 1'b0;
        out_clock_comp <= 1'b1;
        dataOut <= scrambled;
        range_exceeded_flag <= overflowNow;
        ditherOut <= ctrl_reg[`CTRL_DITHER_BIT] ? prngValue : {WIDTH{1'b0}};
      end
    end
  end

  // ************************************************************
  // Interrupt status and mask
  // ************************************************************
  reg [`ST_WIDTH-1:0] status_reg;
  reg [`ST_WIDTH-1:0] mask_reg;
  reg [`ST_WIDTH-1:0] status_next;
  wire [`ST_WIDTH-1:0] events;
  wire wrFire;
  wire [31:0] wrData;
  wire [3:0] wrAddr;
  reg awHigh_reg;
  reg wStrb_reg;

  assign events = {sampleFall & overflowNow, sampleFall};

  always @* begin
    status_next = status_reg;
    if (wrFire && !awHigh_reg && wrAddr == `REG_STATUS && wStrb_reg) begin
      status_next = status_next & ~wrData[`ST_WIDTH-1:0];
    end
    status_next = status_next | events;
  end

  always @(posedge clk) begin
    if (reset) begin
      status_reg <= {`ST_WIDTH{1'b0}};
      irq <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq <= |(status_next & mask_reg);
    end
  end

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  reg awHeld_reg;
  reg wHeld_reg;
  reg [3:0] awAddr_reg;
  reg [31:0] wData_reg;

  assign wrFire = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
  assign wrAddr = awAddr_reg;
  assign wrData = wData_reg;

  always @(posedge clk) begin
    if (reset) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 4'h0;
      wData_reg <= 32'h00000000;
      awHigh_reg <= 1'b0;
      wStrb_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      ctrl_reg <= `CTRL_RESET_VAL;
      mask_reg <= {`ST_WIDTH{1'b0}};
    end else begin
      s_axi_awready <= ~awHeld_reg & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~wHeld_reg & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr[3:0];
        awHigh_reg <= |s_axi_awaddr[31:4];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb[0];
      end
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RESP_OKAY;
        // Upper address bits set select an unused index
        case (awHigh_reg ? 4'h1 : wrAddr)
          `REG_CTRL: begin
            if (wStrb_reg) begin
              ctrl_reg[`CTRL_DITHER_BIT] <= wrData[`CTRL_DITHER_BIT];
            end
          end
          `REG_MASK: begin
            if (wStrb_reg) begin
              mask_reg <= wrData[`ST_WIDTH-1:0];
            end
          end
          `REG_STATUS: begin
          end
          default: begin
            s_axi_bresp <= `RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
      end
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  always @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case ((|s_axi_araddr[31:4]) ? 4'h1 : s_axi_araddr[3:0])
          `REG_CTRL: s_axi_rdata <= ctrl_reg;
          `REG_STATUS: s_axi_rdata <= {{(32-`ST_WIDTH){1'b0}}, status_reg};
          `REG_MASK: s_axi_rdata <= {{(32-`ST_WIDTH){1'b0}}, mask_reg};
          `REG_SAMPLE: s_axi_rdata <= {{(32-WIDTH-1){1'b0}}, range_exceeded_flag, dataOut};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

//--- adc_output_scrambler_out_clock_true_asserts.sv
`timescale 1ns/1ps
module adc_output_scrambler_out_clock_true_asserts #(
  parameter WIDTH = 16
) (
  input wire clk,
  input wire reset,
  input wire sampleClock,
  input wire [WIDTH-1:0] rawResult,
  input wire overRange,
  input wire underRange,
  input wire scramble_enable,
  input wire formatTwos,
  input wire [WIDTH-1:0] dataOut,
  input wire range_exceeded_flag,
  input wire out_clock_true,
  input wire out_clock_comp,
  input wire [WIDTH-1:0] ditherOut,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  function automatic [WIDTH-1:0] shape(input [WIDTH-1:0] w, input twos, input scr);
    shape = twos ? w ^ {1'b1, {(WIDTH-1){1'b0}}} : w;
    if (scr) shape = shape ^ {{(WIDTH-1){shape[0]}}, 1'b0};
  endfunction
  sequence clkFall;
    $fell(out_clock_true);
  endsequence
  clk_pair_a: assert property (out_clock_comp != out_clock_true)
    else $error("Output clocks not complementary");
  clk_delay_a: assert property ($rose(sampleClock) |-> ##[3:5] $rose(out_clock_true))
    else $error("Output clock did not follow sample clock");
  data_edge_a: assert property ($changed(dataOut) || $changed(range_exceeded_flag) |-> clkFall)
    else $error("Data changed away from output clock fall");
  word_value_a: assert property (clkFall |-> dataOut == shape($past(rawResult, 4) - ditherOut,
    $past(formatTwos, 4), $past(scramble_enable, 4))) else $error("Output word wrong");
  flag_value_a: assert property (clkFall |-> range_exceeded_flag == ($past(overRange, 4) || $past(underRange, 4)))
    else $error("Range flag wrong");
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
    else $error("Write response late");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("Write response dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped");
endmodule

//--- adc_output_scrambler_out_clock_true_bench.sv
`timescale 1ns/1ps
module adc_output_scrambler_out_clock_true_bench;
  logic clk = 0, reset = 1, sampleClock = 0, overRange = 0, underRange = 0, scramble_enable = 0, formatTwos = 0;
  logic [15:0] rawResult = 16'h0000, prev = 16'h0000;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire [15:0] dataOut, ditherOut, capWord;
  wire range_exceeded_flag, out_clock_true, out_clock_comp, irq, capFlag;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int errCount = 0, nCompared = 0, cycles = 0, i;
  adc_output_scrambler_out_clock_true DUT (.*);
  adc_capture_model capture (.latchClock(out_clock_true), .descramble(scramble_enable), .dataIn(dataOut),
    .flagIn(range_exceeded_flag), .word(capWord), .flag(capFlag));
  initial forever #4 clk = ~clk;
  initial begin
    #2.25;
    forever #62.5 sampleClock = ~sampleClock;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      stopTest();
    end
  end
  task check(input [31:0] seen, input [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errCount++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task axw(input [31:0] a, input [31:0] v, input [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    check(s_axi_bresp, er);
    @(posedge clk);
  endtask
  task axr(input [31:0] a, input [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 0;
    check(s_axi_rresp, er);
    @(posedge clk);
  endtask
  function automatic [15:0] step(input [15:0] v);
    step = (v >> 1) ^ (v[0] ? 16'hB400 : 16'h0000);
  endfunction
  task smp(input [15:0] raw, input ov, input un, input sc, input tw, input dith);
    logic [15:0] e;
    @(posedge out_clock_true);
    @(posedge clk);
    rawResult <= raw;
    overRange <= ov;
    underRange <= un;
    scramble_enable <= sc;
    formatTwos <= tw;
    @(posedge out_clock_true);
    #1;
    e = raw - ditherOut;
    if (tw) e = e ^ 16'h8000;
    check(capWord, e);
    check(dataOut, sc ? e ^ {{15{e[0]}}, 1'b0} : e);
    check(capFlag, ov | un);
    if (!dith) check(ditherOut, 32'h0);
    else if (prev != 16'h0000) check(ditherOut, step(step(prev)));
    prev = dith ? ditherOut : 16'h0000;
  endtask
  task stopTest();
    $display("Compared %0d, mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hD86775B8));
    repeat (5) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    // ************************************************************
    // Registers
    // ************************************************************
    axr(32'h0, 2'h0);
    check(d, 32'h0);
    axr(32'h10, 2'h2);
    check(d, 32'h0);
    axw(32'h10, 32'h1, 2'h2);
    axw(32'h0, 32'h1, 2'h0);
    axr(32'h0, 2'h0);
    check(d, 32'h1);
    axw(32'h0, 32'h0, 2'h0);
    $display("Test registers done");
    // ************************************************************
    // Sample path, all modes, dither off then on
    // ************************************************************
    for (i = 0; i < 32; i++) begin
      if (i == 16) axw(32'h0, 32'h1, 2'h0);
      smp(i % 16 < 2 ? {16{i[0]}} : 16'($urandom), i[2] & i[3], i[2] & !i[3], i[0], i[1], i >= 16);
    end
    $display("Test samples done");
    // ************************************************************
    // Interrupts
    // ************************************************************
    axw(32'h0, 32'h0, 2'h0);
    axw(32'h8, 32'h2, 2'h0);
    smp(16'h1234, 1, 0, 0, 0, 0);
    check(irq, 32'h1);
    axr(32'h4, 2'h0);
    check(d[1], 32'h1);
    axw(32'h8, 32'h0, 2'h0);
    repeat (2) @(posedge clk);
    check(irq, 32'h0);
    axw(32'h8, 32'h2, 2'h0);
    smp(16'h4321, 0, 0, 0, 0, 0);
    axr(32'hC, 2'h0);
    check(d, 32'h00004321);
    axr(32'h8, 2'h0);
    check(d, 32'h2);
    axw(32'h4, 32'h2, 2'h0);
    repeat (2) @(posedge clk);
    check(irq, 32'h0);
    $display("Test interrupts done");
    stopTest();
  end
endmodule
bind adc_output_scrambler_out_clock_true adc_output_scrambler_out_clock_true_asserts #(.WIDTH(WIDTH)) chk (.*);

//--- dither_prng.v
`timescale 1ns/1ps
`include "adc_out_defines.vh"
// ************************************************************
// Long-sequence pseudo-random generator, one step per enable
// ************************************************************
module dither_prng #(
  parameter WIDTH = 16
) (
  input wire clk,
  input wire reset,
  input wire step,
  output wire [WIDTH-1:0] value
);
  reg [WIDTH-1:0] state_reg;
  reg [WIDTH-1:0] state_next;

  always @* begin
    state_next = state_reg;
    if (step) begin
      if (state_reg[0]) begin
        state_next = (state_reg >> 1) ^ `LFSR_TAPS;
      end else begin
        state_next = state_reg >> 1;
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      state_reg <= `LFSR_SEED;
    end else begin
      state_reg <= state_next;
    end
  end

  assign value = state_reg;
endmodule
